// ==== rtl/acc_pkg.sv ====
// Shared constants and state layout for the converter control block.
// Assumes a single 25 MHz CPU-side clock and control bits on plain ports.
package acc_pkg;

  // ********************************************************
  // Result and conversion timing
  // ********************************************************
  localparam int unsigned RESULT_W           = 10;
  localparam logic [4:0]  CONV_CYCLES        = 5'h0d;  // 13 converter clocks
  localparam logic [4:0]  FIRST_CONV_CYCLES  = 5'h19;  // 25 converter clocks
  localparam logic [4:0]  SAMPLE_CYCLE       = 5'h01;
  localparam logic [4:0]  FIRST_SAMPLE_CYCLE = 5'h0d;
  localparam logic [4:0]  TRIAL_START        = 5'h02;
  localparam logic [4:0]  FIRST_TRIAL_START  = 5'h0e;
  localparam logic [4:0]  TRIAL_COUNT        = 5'h0a;
  localparam logic [7:0]  PRESCALE_MAX_TOP   = 8'hff;

  // ********************************************************
  // Selection encodings
  // ********************************************************
  localparam logic [2:0] TRIG_FREE_RUN   = 3'h0;  // Source 0 is free running, restarted at each conversion end
  localparam logic [4:0] CHAN_PIN_LAST   = 5'h07;
  localparam logic [4:0] CHAN_GAIN_FIRST = 5'h08;
  localparam logic [4:0] CHAN_GAIN_LAST  = 5'h0f;
  localparam logic [4:0] CHAN_BANDGAP    = 5'h1e;
  localparam logic [4:0] CHAN_GROUND     = 5'h1f;
  localparam logic [1:0] GAIN_1X         = 2'h0;
  localparam logic [1:0] GAIN_10X        = 2'h1;
  localparam logic [1:0] GAIN_200X       = 2'h2;
  localparam logic [1:0] REF_EXTERNAL    = 2'h0;
  localparam logic [1:0] REF_SUPPLY      = 2'h1;
  localparam logic [1:0] REF_INTERNAL    = 2'h3;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [1:0] RST_REF  = REF_EXTERNAL;
  localparam logic [4:0] RST_CHAN = 5'h00;

  typedef struct packed {
    logic                compMeta;
    logic                compSync;
    logic [7:0]          presCnt;
    logic                goPend;
    logic                busy;
    logic                firstConv;
    logic [4:0]          cycCnt;
    logic [RESULT_W-1:0] sarCode;
    logic [RESULT_W-1:0] result;
    logic                lock;
    logic                doneFlag;
    logic                trigPrev;
    logic                irq;
    logic                convGo;
    logic [7:0]          resHi;
    logic [7:0]          resLo;
    logic [1:0]          refApplied;
    logic [4:0]          chanApplied;
    logic                gainBypass;
    logic [1:0]          gainCode;
    logic                sampleHold;
    logic                analogOn;
  } acc_state_type;

endpackage

// ==== rtl/acc_conversion_control.sv ====
// Digital control of a 10-bit successive-approximation converter.
// Assumes control bits and read strobes come from CPU logic on ref_clk;
// only the comparator output arrives from the analog side.
`timescale 1ns/1ps

module acc_conversion_control (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       converterOn,
  input  wire logic       convGoSet,
  input  wire logic       autoTriggerOn,
  input  wire logic [2:0] triggerSourceSelect,
  input  wire logic [7:0] triggerSources,
  input  wire logic [2:0] prescaleSelect,
  input  wire logic [1:0] referenceSelect,
  input  wire logic [4:0] channelGainSelect,
  input  wire logic       leftJustify,
  input  wire logic       resultLowRead,
  input  wire logic       resultHighRead,
  input  wire logic       doneFlagClear,
  input  wire logic       doneIntEnable,
  input  wire logic       globalIntEnable,
  input  wire logic       compIn,
  output logic      [7:0] resultHighByte,
  output logic      [7:0] resultLowByte,
  output logic            convGoStatus,
  output logic            conversionDoneFlag,
  output logic            convIrq,
  output logic      [9:0] dacCode,
  output logic            sampleHold,
  output logic            analogOn,
  output logic      [1:0] referenceApplied,
  output logic      [4:0] channelApplied,
  output logic            gainBypass,
  output logic      [1:0] gainCode
);

  // ********************************************************
  // Reset release
  // ********************************************************
  logic rstMeta_q;
  logic rstSyncN_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_q  <= 1'b0;
      rstSyncN_q <= 1'b0;
    end else begin
      rstMeta_q  <= 1'b1;
      rstSyncN_q <= rstMeta_q;
    end
  end

  // ********************************************************
  // State
  // ********************************************************
  acc_pkg::acc_state_type state_q;
  acc_pkg::acc_state_type state_d;

  always_comb begin
    logic       tick;
    logic       freeRun;
    logic       trigSel;
    logic       trigEdge;
    logic       lastCyc;
    logic       selUpdate;
    logic [7:0] presTop;
    logic [4:0] convLen;
    logic [4:0] trialBase;
    logic [4:0] sampleAt;
    logic [4:0] trialIdx;
    tick      = 1'b0;
    freeRun   = 1'b0;
    trigSel   = 1'b0;
    trigEdge  = 1'b0;
    lastCyc   = 1'b0;
    selUpdate = 1'b0;
    presTop   = 8'h00;
    convLen   = 5'h00;
    trialBase = 5'h00;
    sampleAt  = 5'h00;
    trialIdx  = 5'h00;

    state_d = state_q;

    // Comparator crosses from the analog side
    state_d.compMeta = compIn;
    state_d.compSync = state_q.compMeta;

    // Power of two division from 2 to 256
    presTop = acc_pkg::PRESCALE_MAX_TOP >> (3'h7 - prescaleSelect);
    tick    = (state_q.presCnt == presTop);

    // ******************************************************
    // Trigger selection
    // ******************************************************
    freeRun  = autoTriggerOn && (triggerSourceSelect == acc_pkg::TRIG_FREE_RUN);
    trigSel  = triggerSources[triggerSourceSelect];
    state_d.trigPrev = trigSel;
    // Only a rising edge counts, so a level left high starts nothing
    trigEdge = autoTriggerOn && !freeRun && trigSel && !state_q.trigPrev;

    // ******************************************************
    // Conversion length
    // ******************************************************
    convLen   = state_q.firstConv ? acc_pkg::FIRST_CONV_CYCLES : acc_pkg::CONV_CYCLES;
    trialBase = state_q.firstConv ? acc_pkg::FIRST_TRIAL_START : acc_pkg::TRIAL_START;
    sampleAt  = state_q.firstConv ? acc_pkg::FIRST_SAMPLE_CYCLE : acc_pkg::SAMPLE_CYCLE;
    lastCyc   = state_q.busy && tick && (state_q.cycCnt == convLen - 5'h01);
    trialIdx  = state_q.cycCnt - trialBase;

    state_d.sampleHold = 1'b0;

    if (!converterOn) begin
      // Whole converter held idle, prescaler in reset
      state_d.presCnt   = 8'h00;
      state_d.busy      = 1'b0;
      state_d.goPend    = 1'b0;
      state_d.firstConv = 1'b1;
      state_d.cycCnt    = 5'h00;
      state_d.sarCode   = '0;
      state_d.analogOn  = 1'b0;
    end else begin
      state_d.analogOn = 1'b1;
      state_d.presCnt  = tick ? 8'h00 : state_q.presCnt + 8'h01;

      // A write of one while already converting changes nothing
      if (convGoSet && !state_q.busy) begin
        state_d.goPend = 1'b1;
      end

      if (trigEdge && !state_q.busy && !state_q.goPend) begin
        // Restart prescaler so the trigger-to-sample delay is fixed
        state_d.presCnt = 8'h00;
        state_d.busy    = 1'b1;
        state_d.cycCnt  = 5'h00;
        state_d.sarCode = '0;
      end else if (tick) begin
        if (!state_q.busy) begin
          if (state_q.goPend) begin
            state_d.goPend  = 1'b0;
            state_d.busy    = 1'b1;
            state_d.cycCnt  = 5'h00;
            state_d.sarCode = '0;
          end
        end else begin
          state_d.cycCnt = state_q.cycCnt + 5'h01;
          if (state_q.cycCnt == sampleAt) begin
            state_d.sampleHold = 1'b1;
          end

          // Successive approximation, one decision per converter clock
          if (state_q.cycCnt >= trialBase) begin
            for (int i = 0; i < acc_pkg::RESULT_W; i++) begin
              if ((trialIdx != 5'h00) && (5'(i) == acc_pkg::TRIAL_COUNT - trialIdx) && !state_q.compSync) begin
                state_d.sarCode[i] = 1'b0;
              end
              if ((trialIdx < acc_pkg::TRIAL_COUNT) && (5'(i) == acc_pkg::TRIAL_COUNT - 5'h01 - trialIdx)) begin
                state_d.sarCode[i] = 1'b1;
              end
            end
          end

          if (lastCyc) begin
            state_d.busy      = 1'b0;
            state_d.firstConv = 1'b0;
            state_d.cycCnt    = 5'h00;
            // A locked pair keeps the older result
            if (!state_q.lock) begin
              state_d.result = state_d.sarCode;
            end
            if (freeRun) begin
              // Next conversion begins at once, go stays high
              state_d.busy    = 1'b1;
              state_d.sarCode = '0;
            end
          end
        end
      end
    end

    // ******************************************************
    // Result lock
    // ******************************************************
    if (resultLowRead) begin
      state_d.lock = 1'b1;
    end
    if (resultHighRead) begin
      state_d.lock = 1'b0;
    end

    // ******************************************************
    // Done flag, set wins over clear
    // ******************************************************
    if (doneFlagClear) begin
      state_d.doneFlag = 1'b0;
    end
    if (lastCyc) begin
      state_d.doneFlag = 1'b1;
    end
    state_d.irq    = state_d.doneFlag && doneIntEnable && globalIntEnable;
    state_d.convGo = state_d.goPend || state_d.busy;

    // ******************************************************
    // Selection applied to the analog front end
    // ******************************************************
    // Held while off so the multiplexer is not disturbed
    selUpdate = converterOn && (!state_q.busy || lastCyc);
    if (selUpdate) begin
      state_d.refApplied  = referenceSelect;
      state_d.chanApplied = channelGainSelect;
      if ((channelGainSelect <= acc_pkg::CHAN_PIN_LAST) || (channelGainSelect == acc_pkg::CHAN_BANDGAP)
          || (channelGainSelect == acc_pkg::CHAN_GROUND)) begin
        state_d.gainBypass = 1'b1;
        state_d.gainCode   = acc_pkg::GAIN_1X;
      end else if ((channelGainSelect >= acc_pkg::CHAN_GAIN_FIRST)
                   && (channelGainSelect <= acc_pkg::CHAN_GAIN_LAST)) begin
        state_d.gainBypass = 1'b0;
        case (channelGainSelect[2:1])
          2'h1: begin
            state_d.gainCode = acc_pkg::GAIN_10X;
          end
          2'h2: begin
            state_d.gainCode = acc_pkg::GAIN_200X;
          end
          default: begin
            state_d.gainCode = acc_pkg::GAIN_1X;
          end
        endcase
      end else begin
        // Remaining differential codes share the common negative input
        state_d.gainBypass = 1'b0;
        state_d.gainCode   = acc_pkg::GAIN_1X;
      end
    end

    // ******************************************************
    // Justification of the result bytes
    // ******************************************************
    if (leftJustify) begin
      state_d.resHi = state_d.result[9:2];
      state_d.resLo = {state_d.result[1:0], 6'h00};
    end else begin
      state_d.resHi = {6'h00, state_d.result[9:8]};
      state_d.resLo = state_d.result[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstSyncN_q) begin
    if (!rstSyncN_q) begin
      state_q             <= '0;
      state_q.firstConv   <= 1'b1;
      state_q.refApplied  <= acc_pkg::RST_REF;
      state_q.chanApplied <= acc_pkg::RST_CHAN;
      state_q.gainBypass  <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // ********************************************************
  // Outputs, all straight from the state register
  // ********************************************************
  assign resultHighByte     = state_q.resHi;
  assign resultLowByte      = state_q.resLo;
  assign convGoStatus       = state_q.convGo;
  assign conversionDoneFlag = state_q.doneFlag;
  assign convIrq            = state_q.irq;
  assign dacCode            = state_q.sarCode;
  assign sampleHold         = state_q.sampleHold;
  assign analogOn           = state_q.analogOn;
  assign referenceApplied   = state_q.refApplied;
  assign channelApplied     = state_q.chanApplied;
  assign gainBypass         = state_q.gainBypass;
  assign gainCode           = state_q.gainCode;

endmodule

// ==== test/acc_conversion_control_sva.sv ====
// Port checks for the converter control block.
// Assumes one clock domain; bound to every acc_conversion_control.
`timescale 1ns/1ps
module acc_conversion_control_sva (
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       converterOn,
  input wire logic       convGoSet,
  input wire logic       doneIntEnable,
  input wire logic       globalIntEnable,
  input wire logic       convGoStatus,
  input wire logic       conversionDoneFlag,
  input wire logic       convIrq,
  input wire logic       sampleHold,
  input wire logic [1:0] referenceApplied,
  input wire logic [4:0] channelApplied,
  input wire logic       gainBypass,
  input wire logic [1:0] gainCode
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Four cycles sit well inside the shortest frozen span any divisor allows
  sequence s_held;
    ($stable(channelApplied) && $stable(referenceApplied)) [*4];
  endsequence
  sequence s_pair;
    channelApplied[4:3] == 2'h1;
  endsequence
  go_answer_a: assert property (convGoSet && converterOn && !convGoStatus |=> convGoStatus)
    else $error("go not raised after request");
  go_end_flag_a: assert property ($fell(convGoStatus) && converterOn &&
    $past(converterOn) |-> conversionDoneFlag)
    else $error("go fell without done flag");
  off_idle_a: assert property (!converterOn [*2] |-> !convGoStatus)
    else $error("conversion alive while off");
  bypass_single_a: assert property (channelApplied <= acc_pkg::CHAN_PIN_LAST ||
    channelApplied >= acc_pkg::CHAN_BANDGAP |-> gainBypass)
    else $error("single ended input not bypassed");
  gain_pair_a: assert property (s_pair |-> !gainBypass && gainCode == (channelApplied[2:1] == 2'h1 ?
    acc_pkg::GAIN_10X : channelApplied[2:1] == 2'h2 ? acc_pkg::GAIN_200X : acc_pkg::GAIN_1X))
    else $error("gain pair setting wrong");
  select_frozen_a: assert property (sampleHold |=> s_held)
    else $error("selection moved during conversion");
  sample_pulse_a: assert property (sampleHold |-> convGoStatus ##1 !sampleHold)
    else $error("sample point outside busy go");
  irq_gate_a: assert property (convIrq |-> conversionDoneFlag)
    else $error("interrupt without done flag");
  irq_raise_a: assert property ((conversionDoneFlag && doneIntEnable && globalIntEnable) [*2]
    |-> convIrq)
    else $error("interrupt missing");
endmodule

bind acc_conversion_control acc_conversion_control_sva u_sva (
  .ref_clk, .rstn, .converterOn, .convGoSet, .doneIntEnable, .globalIntEnable, .convGoStatus,
  .conversionDoneFlag, .convIrq, .sampleHold, .referenceApplied, .channelApplied, .gainBypass, .gainCode
);

// ==== test/acc_analog_model.sv ====
// Analog side: comparator against an input held as a code.
// Assumes dacCode is the design's current trial code.
`timescale 1ns/1ps
module acc_analog_model (
  input  wire logic [9:0] vinCode,
  input  wire logic [9:0] dacCode,
  output logic            compIn
);
  // ****
  // Comparator
  // ****
  // Input sits half a step above its code, so no trial ever ties
  assign compIn = {vinCode, 1'b1} > {dacCode, 1'b0};
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the converter control block.
// Assumes the analog model closes the comparator loop.
`timescale 1ns/1ps
module tb_top;
  // ****
  // Signals
  // ****
  typedef struct {logic [15:0] res; int t0; int lo; int hi;} acc_note_type;
  logic ref_clk = 0, rstn = 0, converterOn = 0, convGoSet = 0, autoTriggerOn = 0, leftJustify = 0;
  logic resultLowRead = 0, resultHighRead = 0, doneFlagClear = 0, doneIntEnable = 0, globalIntEnable = 0;
  logic [2:0] triggerSourceSelect = 0, prescaleSelect = 3'h2;
  logic [7:0] triggerSources = 0;
  logic [1:0] referenceSelect = 0, g;
  logic [4:0] channelGainSelect = 0, c;
  logic [9:0] vinCode = 0, v, dacCode;
  logic [7:0] resultHighByte, resultLowByte;
  logic convGoStatus, conversionDoneFlag, convIrq, sampleHold, analogOn, gainBypass, compIn, flagSeen = 0;
  logic [1:0] referenceApplied, gainCode;
  logic [4:0] channelApplied;
  logic [15:0] last;
  logic [4:0] codes [9] = '{5'h00, 5'h07, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h1e, 5'h1f};
  logic [1:0] refs [3] = '{2'h0, 2'h1, 2'h3};
  int mismatches = 0, checks = 0, cyc = 0, shCnt = 0, div, s, s0;
  acc_note_type notes [$];
  acc_note_type n;

  acc_conversion_control dut (.ref_clk, .rstn, .converterOn, .convGoSet, .autoTriggerOn,
    .triggerSourceSelect, .triggerSources, .prescaleSelect, .referenceSelect, .channelGainSelect,
    .leftJustify, .resultLowRead, .resultHighRead, .doneFlagClear, .doneIntEnable, .globalIntEnable,
    .compIn, .resultHighByte, .resultLowByte, .convGoStatus, .conversionDoneFlag, .convIrq, .dacCode,
    .sampleHold, .analogOn, .referenceApplied, .channelApplied, .gainBypass, .gainCode);
  acc_analog_model u_analog (.vinCode, .dacCode, .compIn);

  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  // ****
  // Helpers
  // ****
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s2);
    checks++;
    if (s2 !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, s2);
    end
  endtask
  function automatic logic [15:0] pack(logic [9:0] x, logic l);
    return l ? {x, 6'h00} : {6'h00, x};
  endfunction
  task automatic tick(int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic pulse(ref logic p);
    p = 1;
    tick(1);
    p = 0;
  endtask
  // Window spans only the wait for the first converter clock after go
  task automatic note(logic [15:0] r, int lo, int hi);
    notes.push_back('{r, cyc, lo, hi});
  endtask
  task automatic waitFlag();
    for (int k = 0; k < 9000 && conversionDoneFlag !== 1'b1; k++) tick(1);
    chk("done flag", 1'b1, conversionDoneFlag);
  endtask
  task automatic conv(logic [9:0] x, int t, logic [15:0] r, logic [4:0] ch);
    vinCode = x;
    c = channelGainSelect;
    note(r, t * div + 2, (t + 1) * div + 1);
    pulse(convGoSet);
    chk("go busy", 1'b1, convGoStatus);
    // Change lands after the start, so the old channel must stay applied
    tick(2 * div);
    channelGainSelect = ch;
    tick(1);
    chk("channel held", c, channelApplied);
    waitFlag();
    chk("go cleared", 1'b0, convGoStatus);
    chk("irq", doneIntEnable & globalIntEnable, convIrq);
    tick(1);
    chk("channel", ch, channelApplied);
    pulse(doneFlagClear);
  endtask

  // ****
  // Result monitor
  // ****
  always @(negedge ref_clk) begin
    shCnt += sampleHold;
    if (conversionDoneFlag === 1'b1 && !flagSeen) begin
      if (notes.size() == 0) chk("extra result", 16'h0000, 16'hffff);
      else begin
        n = notes.pop_front();
        chk("result", n.res, {resultHighByte, resultLowByte});
        chk("latency", 1'b1, cyc - n.t0 >= n.lo && cyc - n.t0 <= n.hi);
      end
    end
    flagSeen = conversionDoneFlag;
  end

  initial begin
    #(40 * 60000);
    mismatches++;
    complete_run();
  end

  // ****
  // Scenarios
  // ****
  initial begin
    void'($urandom(32'h6308c306));
    prescaleSelect = 3'h2 + 3'($urandom_range(1));
    div = 2 ** (prescaleSelect + 1);
    tick(16);
    rstn = 1;
    tick(4);
    channelGainSelect = 5'h05;
    referenceSelect = 2'h3;
    tick(3);
    chk("off channel", 5'h00, channelApplied);
    chk("off reference", 2'h0, referenceApplied);
    chk("off analog", 1'b0, analogOn);
    converterOn = 1;
    for (int i = 0; i < 9; i++) begin
      c = codes[i];
      channelGainSelect = c;
      referenceSelect = refs[i % 3];
      tick(3);
      g = (c[4:3] == 2'h1) ? ((c[2:1] == 2'h1) ? 2'h1 : (c[2:1] == 2'h2) ? 2'h2 : 2'h0) : 2'h0;
      chk("analog on", 1'b1, analogOn);
      chk("channel", c, channelApplied);
      chk("bypass", c <= 5'h07 || c >= 5'h1e, gainBypass);
      chk("gain", g, gainCode);
      chk("reference", refs[i % 3], referenceApplied);
    end
    v = 10'($urandom);
    conv(v, 25, pack(v, 1'b0), 5'h02);
    for (int i = 0; i < 4; i++) begin
      leftJustify = 1'($urandom);
      doneIntEnable = 1'($urandom);
      globalIntEnable = i[1] | 1'($urandom);
      v = (i < 2) ? {10{i[0]}} : 10'($urandom);
      last = pack(v, leftJustify);
      conv(v, 13, last, 5'($urandom_range(7)));
    end
    pulse(resultLowRead);
    conv(10'($urandom), 13, last, 5'h01);
    pulse(resultHighRead);
    v = 10'($urandom);
    conv(v, 13, pack(v, leftJustify), 5'h01);
    autoTriggerOn = 1;
    s = 1 + $urandom_range(6);
    triggerSourceSelect = 3'(s);
    v = 10'($urandom);
    vinCode = v;
    // Trigger start zeroes the prescaler, so the latency is exact
    note(pack(v, leftJustify), 13 * div + 1, 13 * div + 1);
    triggerSources[s] = 1;
    tick(3 * div);
    triggerSources[s] = 0;
    tick(1);
    triggerSources[s] = 1;
    waitFlag();
    pulse(doneFlagClear);
    triggerSources = 8'($urandom) | 8'(1 << s);
    tick(20 * div);
    chk("no retrigger", 1'b0, convGoStatus | conversionDoneFlag);
    v = 10'($urandom);
    conv(v, 13, pack(v, leftJustify), 5'h01);
    triggerSources = 0;
    triggerSourceSelect = 3'h0;
    v = 10'($urandom);
    vinCode = v;
    note(pack(v, leftJustify), 13 * div + 2, 14 * div + 1);
    s0 = shCnt;
    pulse(convGoSet);
    tick(45 * div);
    chk("free run go", 1'b1, convGoStatus);
    chk("free run count", 1'b1, shCnt - s0 >= 3);
    autoTriggerOn = 0;
    for (int k = 0; k < 9000 && convGoStatus !== 1'b0; k++) tick(1);
    pulse(doneFlagClear);
    pulse(convGoSet);
    tick(4 * div);
    converterOn = 0;
    tick(2);
    chk("off go", 1'b0, convGoStatus);
    chk("off analog", 1'b0, analogOn);
    converterOn = 1;
    tick(2);
    v = 10'($urandom);
    conv(v, 25, pack(v, leftJustify), 5'h03);
    complete_run();
  end
endmodule
